// File: rtl/itb_pkg.sv
/*
 * constants shared by both ends of the interval timer bit-bus link.
 * assumes a single 100 mhz system clock on both ends.
 */
// Function
// - first written bit selects clock or mask mode
// - clock mode bits one-fourteen hold interval
// - writing bit fourteen starts the countdown
// - count decrements once per 64 clocks
// - full interval 16383 counts runs to zero
// - reaching zero raises the timer interrupt level
// - host enables mask bit three first
// - host clears pending timer interrupt in handler
// - mask bit three written one clears pending
// - readback: mask mode for HOLD_CYC clocks, then back
// - clock mode reads return captured count copy
// - device at bit address 80, base 100
// - processor level three or higher accepts it
package itb_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int DEV_PRESCALE = 64;
    localparam int HOLD_NS = 21400;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;

    // ----------------------------------------------------------------
    // bit bus map
    // ----------------------------------------------------------------
    localparam int BIT_ADDR_W = 12;
    localparam logic [11:0] DEV_BIT_ADDR = 12'h080;
    localparam logic [12:0] SW_BASE = 13'h0100;
    localparam logic [3:0] MODE_BIT = 4'h0;
    localparam logic [3:0] INTERVAL_BIT_FIRST = 4'h1;
    localparam logic [3:0] INTERVAL_BIT_LAST = 4'he;
    localparam logic [3:0] TIMER_MASK_BIT = 4'h3;
    localparam logic [3:0] SUMMARY_BIT = 4'hf;
    localparam int IVAL_W = 14;
    localparam logic [13:0] IVAL_RST = 14'h0000;
    localparam logic [15:1] MASK_RST = 15'h0000;

    // ----------------------------------------------------------------
    // controller registers (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_RDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_ISTAT = 8'h10;
    localparam logic [7:0] REG_IMASK = 8'h14;
    localparam logic [7:0] REG_LEVEL = 8'h18;

    // cmd fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_IDX_LSB = 4;
    localparam int CMD_NB_LSB = 8;
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_SET_ONE = 3'h1;
    localparam logic [2:0] OP_SET_ZERO = 3'h2;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_SNAP = 3'h4;

    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TIMER = 1;
    localparam logic [3:0] TIMER_LEVEL = 4'h3;
    localparam logic [3:0] LEVEL_RST = 4'h0;

endpackage

// File: rtl/itb_bus_if.sv
/*
 * serial_bit_io_bus between controller and timer device.
 * assumes both ends share clk_i; no tri-state on this bus.
 */
`timescale 1ns/1ps
`default_nettype none
interface itb_bus_if (
    input wire logic clk_i
);
    logic [11:0] bit_addr;
    logic wr_bit;
    logic wr_stb;
    logic rd_bit;
    logic timer_irq;

    modport dev (
        input bit_addr,
        input wr_bit,
        input wr_stb,
        output rd_bit,
        output timer_irq
    );

    modport host (
        output bit_addr,
        output wr_bit,
        output wr_stb,
        input rd_bit,
        input timer_irq
    );
endinterface
`default_nettype wire

// File: rtl/itb_timer_dev.sv
/*
 * interval timer device on the serial_bit_io_bus.
 * assumes the controller on the same clock drives one bit per
 * write strobe and holds the address while it reads.
 */
`timescale 1ns/1ps
`default_nettype none
module itb_timer_dev #(
    parameter int PRESCALE = itb_pkg::DEV_PRESCALE
) (
    input wire logic clk_i,
    input wire logic rst_i,
    itb_bus_if.dev bus,
    output logic mode_o,
    output logic running_o,
    output logic [13:0] count_o,
    output logic pending_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int PW = $clog2(PRESCALE);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

    typedef struct packed {
        logic mode;
        logic [15:1] mask;
        logic [13:0] ival;
        logic [13:0] cnt;
        logic run;
        logic [13:0] copy;
        logic pend;
        logic [PW-1:0] pre;
        logic rd;
        logic irq;
    } itb_dev_state_t;

    itb_dev_state_t s_q;
    itb_dev_state_t s_d;

    logic tick;
    logic sel;
    logic [3:0] idx;
    logic fire;
    logic clr;
    logic rd_mux;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // only the upper address bits decode; sixteen bits per device
    assign sel = (bus.bit_addr[11:4] == itb_pkg::DEV_BIT_ADDR[11:4]);
    assign idx = bus.bit_addr[3:0];

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 1'b0;
        if (idx == itb_pkg::MODE_BIT) begin
            rd_mux = s_q.mode;
        end else if (idx == itb_pkg::SUMMARY_BIT) begin
            rd_mux = s_q.irq;
        end else if (s_q.mode) begin
            // shared bits show the frozen copy, not the live count
            rd_mux = s_q.copy[idx - 4'h1];
        end else if (idx == itb_pkg::TIMER_MASK_BIT) begin
            rd_mux = s_q.pend;
        end else begin
            rd_mux = s_q.mask[idx];
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        fire = 1'b0;
        clr = 1'b0;

        // prescaler
        tick = (s_q.pre == PRE_LAST);
        if (tick) begin
            s_d.pre = '0;
        end else begin
            s_d.pre = s_q.pre + PW'(1);
        end

        // countdown; reaching zero stops the counter
        if (s_q.run && tick) begin
            if (s_q.cnt <= 14'h0001) begin
                s_d.cnt = 14'h0000;
                s_d.run = 1'b0;
                fire = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 14'h0001;
            end
        end

        // snapshot copy follows the counter in mask mode
        if (!s_q.mode && tick) begin
            s_d.copy = s_q.cnt;
        end

        // bit writes
        if (sel && bus.wr_stb) begin
            if (idx == itb_pkg::MODE_BIT) begin
                s_d.mode = bus.wr_bit;
            end else if (idx == itb_pkg::SUMMARY_BIT) begin
                s_d.mask[15] = bus.wr_bit;
            end else if (s_q.mode) begin
                s_d.ival[idx - 4'h1] = bus.wr_bit;
                if (idx == itb_pkg::INTERVAL_BIT_LAST) begin
                    // restart the prescaler so the first step is a full period
                    s_d.cnt = {bus.wr_bit, s_q.ival[12:0]};
                    s_d.run = 1'b1;
                    s_d.pre = '0;
                end
            end else begin
                s_d.mask[idx] = bus.wr_bit;
                if (idx == itb_pkg::TIMER_MASK_BIT && bus.wr_bit) begin
                    clr = 1'b1;
                end
            end
        end

        // pending flag: a zero reached in the clearing cycle survives
        if (fire) begin
            s_d.pend = 1'b1;
        end else if (clr) begin
            s_d.pend = 1'b0;
        end

        s_d.irq = s_d.pend & s_d.mask[itb_pkg::TIMER_MASK_BIT];
        s_d.rd = sel & rd_mux;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.mode <= 1'b0;
            s_q.mask <= itb_pkg::MASK_RST;
            s_q.ival <= itb_pkg::IVAL_RST;
            s_q.cnt <= itb_pkg::IVAL_RST;
            s_q.run <= 1'b0;
            s_q.copy <= itb_pkg::IVAL_RST;
            s_q.pend <= 1'b0;
            s_q.pre <= '0;
            s_q.rd <= 1'b0;
            s_q.irq <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign bus.rd_bit = s_q.rd;
    assign bus.timer_irq = s_q.irq;
    assign mode_o = s_q.mode;
    assign running_o = s_q.run;
    assign count_o = s_q.cnt;
    assign pending_o = s_q.pend;

endmodule
`default_nettype wire

// File: rtl/itb_host_ctl.sv
/*
 * controller end: classic wishbone slave that turns commands into
 * serial_bit_io_bus bit writes and reads.
 * assumes the device shares clk_i, so its outputs need no synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module itb_host_ctl #(
    parameter logic [12:0] BASE = itb_pkg::SW_BASE,
    parameter int HOLD = itb_pkg::HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    itb_bus_if.host bus
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_WR, ST_RA, ST_RW, ST_RS, ST_SCLR, ST_SHOLD, ST_SSET
    } itb_hst_t;

    typedef struct packed {
        itb_hst_t st;
        logic [2:0] op;
        logic [3:0] idx;
        logic [4:0] nb;
        logic [4:0] pos;
        logic [15:0] wdat;
        logic [15:0] rdat;
        logic [11:0] hold;
        logic [11:0] addr;
        logic wbit;
        logic wstb;
        logic [1:0] istat;
        logic [1:0] imask;
        logic [3:0] level;
        logic tprev;
        logic ack;
        logic [31:0] dout;
    } itb_host_state_t;

    itb_host_state_t s_q;
    itb_host_state_t s_d;

    localparam logic [11:0] HOLD_LAST = 12'(HOLD - 1);
    // the device sees half the software base as its bit address
    localparam logic [11:0] DEV_BASE = BASE[12:1];

    logic req;
    logic wr;
    logic [11:0] cur;
    logic last;
    logic done;
    logic tev;
    logic [4:0] nbf;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wstb = 1'b0;
        done = 1'b0;
        req = wb_cyc_i & wb_stb_i;
        wr = req & wb_we_i & s_q.ack;
        // bits go out lsb first, so data bit 0 lands on device bit idx (the mode bit when idx is 0)
        cur = DEV_BASE + {8'h00, s_q.idx} + {7'h00, s_q.pos};
        last = (s_q.pos + 5'h01 == s_q.nb);
        nbf = wb_dat_i[itb_pkg::CMD_NB_LSB +: 5];

        case (s_q.st)
            ST_IDLE: begin
                if (wr && wb_adr_i == itb_pkg::REG_CMD && wb_sel_i[1:0] == 2'h3) begin
                    s_d.op = wb_dat_i[itb_pkg::CMD_OP_LSB +: 3];
                    s_d.idx = wb_dat_i[itb_pkg::CMD_IDX_LSB +: 4];
                    s_d.nb = (nbf == 5'h00) ? 5'h01 : nbf;
                    s_d.pos = 5'h00;
                    case (s_d.op)
                        itb_pkg::OP_WRITE: s_d.st = ST_WR;
                        itb_pkg::OP_SET_ONE: begin
                            s_d.nb = 5'h01;
                            s_d.wdat = 16'h0001;
                            s_d.st = ST_WR;
                        end
                        itb_pkg::OP_SET_ZERO: begin
                            s_d.nb = 5'h01;
                            s_d.wdat = 16'h0000;
                            s_d.st = ST_WR;
                        end
                        itb_pkg::OP_READ: s_d.st = ST_RA;
                        itb_pkg::OP_SNAP: s_d.st = ST_SCLR;
                        default: s_d.st = ST_IDLE;
                    endcase
                end
            end
            ST_WR: begin
                s_d.addr = cur;
                s_d.wbit = s_q.wdat[s_q.pos[3:0]];
                s_d.wstb = 1'b1;
                s_d.pos = s_q.pos + 5'h01;
                if (last) begin
                    s_d.st = ST_IDLE;
                    done = 1'b1;
                end
            end
            ST_RA: begin
                s_d.addr = cur;
                s_d.st = ST_RW;
            end
            ST_RW: s_d.st = ST_RS;
            ST_RS: begin
                s_d.rdat[s_q.pos[3:0]] = bus.rd_bit;
                s_d.pos = s_q.pos + 5'h01;
                s_d.st = last ? ST_IDLE : ST_RA;
                done = last;
            end
            ST_SCLR: begin
                // mask mode lets the device refresh its count copy
                s_d.addr = DEV_BASE;
                s_d.wbit = 1'b0;
                s_d.wstb = 1'b1;
                s_d.hold = 12'h000;
                s_d.st = ST_SHOLD;
            end
            ST_SHOLD: begin
                s_d.hold = s_q.hold + 12'h001;
                if (s_q.hold == HOLD_LAST) begin
                    s_d.st = ST_SSET;
                end
            end
            ST_SSET: begin
                s_d.addr = DEV_BASE;
                s_d.wbit = 1'b1;
                s_d.wstb = 1'b1;
                s_d.idx = itb_pkg::INTERVAL_BIT_FIRST;
                s_d.nb = 5'(itb_pkg::IVAL_W);
                s_d.pos = 5'h00;
                s_d.rdat = 16'h0000;
                s_d.st = ST_RA;
            end
            default: s_d.st = ST_IDLE;
        endcase

        // software enables mask bit three and clears via set-one; the
        // event only counts at processor level three or more
        s_d.tprev = bus.timer_irq;
        tev = bus.timer_irq & ~s_q.tprev & (s_q.level >= itb_pkg::TIMER_LEVEL);

        // register writes; w1c with set winning over clear
        if (wr && wb_adr_i == itb_pkg::REG_WDATA) begin
            if (wb_sel_i[0] && s_q.st == ST_IDLE) s_d.wdat[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1] && s_q.st == ST_IDLE) s_d.wdat[15:8] = wb_dat_i[15:8];
        end
        if (wr && wb_sel_i[0] && wb_adr_i == itb_pkg::REG_ISTAT) begin
            s_d.istat = s_q.istat & ~wb_dat_i[1:0];
        end
        if (wr && wb_sel_i[0] && wb_adr_i == itb_pkg::REG_IMASK) s_d.imask = wb_dat_i[1:0];
        if (wr && wb_sel_i[0] && wb_adr_i == itb_pkg::REG_LEVEL) s_d.level = wb_dat_i[3:0];
        if (done) s_d.istat[itb_pkg::IRQ_DONE] = 1'b1;
        if (tev) s_d.istat[itb_pkg::IRQ_TIMER] = 1'b1;

        // wishbone answer one cycle after the request
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack) begin
            case (wb_adr_i)
                itb_pkg::REG_WDATA: s_d.dout = {16'h0000, s_q.wdat};
                itb_pkg::REG_RDATA: s_d.dout = {16'h0000, s_q.rdat};
                itb_pkg::REG_STATUS: s_d.dout = {31'h0, s_q.st != ST_IDLE};
                itb_pkg::REG_ISTAT: s_d.dout = {30'h0, s_q.istat};
                itb_pkg::REG_IMASK: s_d.dout = {30'h0, s_q.imask};
                itb_pkg::REG_LEVEL: s_d.dout = {28'h0, s_q.level};
                default: s_d.dout = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.level <= itb_pkg::LEVEL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dout;
    assign wb_ack_o = s_q.ack;
    assign irq_o = |(s_q.istat & s_q.imask);
    assign bus.bit_addr = s_q.addr;
    assign bus.wr_bit = s_q.wbit;
    assign bus.wr_stb = s_q.wstb;

endmodule
`default_nettype wire

// File: verif/itb_link_assertions.sv
/*
 * checker for the bit bus between controller and timer device.
 * assumes one clock, synchronous active-high reset, instanced by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module itb_link_assertions #(
    parameter int PRESCALE = itb_pkg::DEV_PRESCALE
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [11:0] bit_addr_i,
    input wire logic wr_bit_i,
    input wire logic wr_stb_i,
    input wire logic rd_bit_i,
    input wire logic timer_irq_i
);
    // ----------------------------------------------------------------
    // shadow of device state, rebuilt from bit writes
    // ----------------------------------------------------------------
    logic mode_q;
    logic mask3_q;
    logic armed_q;
    logic [13:0] ival_q;
    logic [19:0] since_q;
    logic hit;
    logic clr3;
    logic [19:0] lo;
    assign hit = wr_stb_i && bit_addr_i[11:4] == 8'h08;
    assign clr3 = hit && bit_addr_i[3:0] == 4'h3 && !mode_q && wr_bit_i;
    assign lo = 20'(ival_q) * 20'(PRESCALE);
    // since_q saturates so an idle link never wraps into a false window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= 1'b0;
            mask3_q <= 1'b0;
            armed_q <= 1'b0;
            ival_q <= 14'h0000;
            since_q <= '1;
        end else begin
            if (since_q != '1) since_q <= since_q + 20'h1;
            if (hit && bit_addr_i[3:0] == 4'h0) mode_q <= wr_bit_i;
            if (hit && !mode_q && bit_addr_i[3:0] == 4'h3) mask3_q <= wr_bit_i;
            if (hit && mode_q && bit_addr_i[3:0] inside {[1:14]}) begin
                ival_q[bit_addr_i[3:0] - 4'h1] <= wr_bit_i;
            end
            // a clear disarms; a fresh start is needed before the next rise
            if (clr3) armed_q <= 1'b0;
            if (hit && mode_q && bit_addr_i[3:0] == 4'he) begin
                since_q <= 20'h0;
                armed_q <= 1'b1;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_irq_masked: assert property (!mask3_q |-> !timer_irq_i)
        else $error("timer irq with mask bit three clear");
    a_irq_clears: assert property (clr3 |-> ##1 !timer_irq_i)
        else $error("timer irq survives a clear");
    a_irq_holds: assert property ($fell(timer_irq_i) |-> $past(clr3) || !mask3_q)
        else $error("timer irq dropped without a clear");
    a_irq_timing: assert property ($rose(timer_irq_i) && $past(mask3_q, 2) |->
        since_q >= lo && since_q <= lo + 20'(PRESCALE) + 20'h4)
        else $error("timer irq outside the countdown window");
    a_irq_start: assert property ($rose(timer_irq_i) |-> armed_q)
        else $error("timer irq without a started countdown");
    a_rd_outside: assert property (bit_addr_i[11:4] != 8'h08 |=> !rd_bit_i)
        else $error("read bit driven outside the device range");
    a_mode_read: assert property ($stable(bit_addr_i) && bit_addr_i == 12'h080 && !wr_stb_i
        |=> rd_bit_i == $past(mode_q))
        else $error("bit zero does not read the mode");
    a_irq_bit15: assert property ($stable(bit_addr_i) && bit_addr_i == 12'h08f
        |=> rd_bit_i == $past(timer_irq_i))
        else $error("bit fifteen does not read the timer irq");
    c_start: cover property (hit && mode_q && bit_addr_i[3:0] == 4'he);
    c_fire: cover property ($rose(timer_irq_i));
    c_clear: cover property (clr3);
endmodule
`default_nettype wire

// File: verif/tb_interval_timer_bitbus.sv
/*
 * bench for the interval timer link: wishbone master, both ends joined.
 * assumes the design files and the link checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_interval_timer_bitbus;
    // short prescale keeps the full 14-bit countdown inside the run
    localparam int P = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_q;
    logic wb_ack;
    logic irq;
    logic mode;
    logic running;
    logic [13:0] count;
    logic pending;
    int err_count = 0;
    int n_tests = 0;
    int cyc_n = 0;

    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    itb_bus_if i_itb_bus_if (.clk_i(clk_i));
    itb_timer_dev #(.PRESCALE(P)) i_itb_timer_dev (.clk_i(clk_i), .rst_i(rst_i),
        .bus(i_itb_bus_if), .mode_o(mode), .running_o(running), .count_o(count),
        .pending_o(pending));
    itb_host_ctl #(.HOLD(8)) i_itb_host_ctl (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
        .irq_o(irq), .bus(i_itb_bus_if));
    itb_link_assertions #(.PRESCALE(P)) i_itb_link_assertions (.clk_i(clk_i),
        .rst_i(rst_i), .bit_addr_i(i_itb_bus_if.bit_addr), .wr_bit_i(i_itb_bus_if.wr_bit),
        .wr_stb_i(i_itb_bus_if.wr_stb), .rd_bit_i(i_itb_bus_if.rd_bit),
        .timer_irq_i(i_itb_bus_if.timer_irq));

    // ----------------------------------------------------------------
    // checks and bus cycles
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, input logic [31:0] lo,
        input logic [31:0] hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("Error %0t: %h not in %h..%h", $time, got, lo, hi);
        end
    endtask
    // hold the request until the rising edge that samples ack, take data there
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            err_count++;
            $display("Error %0t: no ack", $time);
        end
        q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, q);
    endtask
    function automatic logic [31:0] mk(input logic [2:0] op, input logic [3:0] idx,
        input logic [4:0] nb);
        return {19'h0, nb, idx, 1'b0, op};
    endfunction
    task automatic cmd(input logic [31:0] c);
        logic [31:0] s;
        int n;
        n = 0;
        wr(itb_pkg::REG_CMD, c);
        do begin
            rd(itb_pkg::REG_STATUS, s);
            n++;
        end while (s[0] !== 1'b0 && n < 100);
        if (s[0] !== 1'b0) begin
            err_count++;
            $display("Error %0t: command stays busy", $time);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] q;
        rd(itb_pkg::REG_LEVEL, q);
        chk(q, 32'h0);
        rd(8'h1c, q);
        chk(q, 32'h0);
        wr(itb_pkg::REG_LEVEL, 32'h3);
        // only the timer event drives irq; the done bit would mask the checks
        wr(itb_pkg::REG_IMASK, 32'h2);
        rd(itb_pkg::REG_LEVEL, q);
        chk(q, 32'h3);
        cmd(mk(itb_pkg::OP_SET_ONE, 4'h3, 5'h00));
        chk(32'(pending), 32'h0);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_fire(input logic [13:0] ival);
        logic [31:0] q;
        int n;
        n = 0;
        wr(itb_pkg::REG_WDATA, {17'h0, ival, 1'b1});
        cmd(mk(itb_pkg::OP_WRITE, 4'h0, 5'h0f));
        chk(32'(mode), 32'h1);
        chk(32'(running), 32'h1);
        while (irq !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk(32'(count), 32'h0);
        chk(32'(pending), 32'h1);
        chk(32'(i_itb_bus_if.timer_irq), 32'h1);
        rd(itb_pkg::REG_ISTAT, q);
        chk(q & 32'h2, 32'h2);
        cmd(mk(itb_pkg::OP_READ, 4'h0, 5'h10));
        rd(itb_pkg::REG_RDATA, q);
        chk(q & 32'h8001, 32'h8001);
    endtask
    task automatic t_clear();
        logic [31:0] q;
        cmd(mk(itb_pkg::OP_SET_ZERO, 4'h0, 5'h00));
        chk(32'(mode), 32'h0);
        chk(32'(pending), 32'h1);
        cmd(mk(itb_pkg::OP_SET_ONE, 4'h3, 5'h00));
        chk(32'(pending), 32'h0);
        chk(32'(i_itb_bus_if.timer_irq), 32'h0);
        wr(itb_pkg::REG_ISTAT, 32'h3);
        rd(itb_pkg::REG_ISTAT, q);
        chk(q & 32'h2, 32'h0);
        chk(32'(irq), 32'h0);
    endtask
    task automatic t_snap();
        logic [31:0] q;
        int t0;
        int t1;
        int n;
        n = 0;
        wr(itb_pkg::REG_WDATA, 32'h7fff);
        cmd(mk(itb_pkg::OP_WRITE, 4'h0, 5'h0f));
        t0 = cyc_n;
        repeat (400) @(posedge clk_i);
        cmd(mk(itb_pkg::OP_SNAP, 4'h0, 5'h00));
        t1 = cyc_n;
        rd(itb_pkg::REG_RDATA, q);
        chk_in(q, 32'h3fff - 32'((t1 - t0) / P) - 32'h2, 32'h3fff - 32'(400 / P) + 32'h1);
        chk(32'(mode), 32'h1);
        while (irq !== 1'b1 && n < 70000) begin
            @(negedge clk_i);
            n++;
        end
        chk_in(32'(cyc_n - t0), 32'(16383 * P - 40), 32'(16383 * P + 8));
        chk(32'(count), 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_fire(14'h0009);
        t_clear();
        t_snap();
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        err_count++;
        $display("Error %0t: watchdog", $time);
        give_verdict();
    end
endmodule
`default_nettype wire
